/* File: lbs_agent.sv */
// processor-side bus agent: issues two-clock requests, samples config at reset
// Notes on behaviour
// - low-active pins count asserted when low
// - clock one address, clock two id
// - capture config at bus reset release
// - drive and sample on rising edge only
// - latch input, react no sooner than next edge
// - pins go straight to or from flops
// - assert T1, seen T2, reply T3, seen T4
// - wired-or signals settle two clocks after release
// - request phase is two clocks long
`timescale 1ns/1ps
`include "lbs_defs.svh"
module lbs_agent (
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  // bus
  lbs_bus_if.dev                   bus,
  // request port
  input  wire logic                req_valid_in,
  output logic                     req_ready_out,
  input  wire lbs_pkg::lbs_lines_t req_addr_in,
  input  wire lbs_pkg::lbs_did_t   req_did_in,
  input  wire lbs_pkg::lbs_len_t   req_len_in,
  output logic                     done_out,
  output logic                     fault_out,
  output logic                     aborted_out,
  // wired-or group
  input  wire lbs_pkg::lbs_wired_t assert_in,
  output lbs_pkg::lbs_wired_t      observed_out,
  // configuration
  output lbs_pkg::lbs_lines_t      cfg_out,
  output logic                     cfg_valid_out,
  output logic                     in_reset_out
);
  import lbs_pkg::*;

  lbs_lines_t     lines_q;
  lbs_wired_t     wired_n_q;
  logic           rst_n_q;
  logic           rst_n_prev_r;
  lbs_wired_t     act_prev_r;
  lbs_wired_t     seen;
  logic           bus_rst;
  logic           rst_release;
  lbs_req_state_t state_r;
  lbs_req_state_t state_nxt;
  logic           strobe_r;
  lbs_lines_t     lines_out_r;
  logic           lines_oe_r;
  logic [1:0]     parity_r;
  lbs_wired_t     drive_r;
  lbs_did_t       did_r;
  lbs_len_t       len_r;

  // capture flops take the pins with nothing in front
  always_ff @(posedge clk_in) begin
    lines_q   <= bus.lines_n;
    wired_n_q <= bus.wired_n;
    rst_n_q   <= bus.reset_n;
  end

  // asserted means electrically low on a _n pin
  assign bus_rst     = ~rst_n_q;
  assign rst_release = ~rst_n_prev_r && rst_n_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rst_n_prev_r <= 1'b0;
      in_reset_out <= 1'b1;
    end else begin
      rst_n_prev_r <= rst_n_q;
      in_reset_out <= bus_rst;
    end
  end

  // config sampled on the inactive-going reset edge, then left alone
  // until a later release; lines_q was latched on that same edge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_out       <= '0;
      cfg_valid_out <= 1'b0;
    end else if (rst_release) begin
      cfg_out       <= ~lines_q;
      cfg_valid_out <= 1'b1;
    end else if (bus_rst) begin
      cfg_valid_out <= 1'b0;     // value kept, only the qualifier drops
    end
  end

  // wired-or settle mask: a fresh low-to-high edge can glitch, so the
  // signal is read as inactive for two clocks afterwards
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      act_prev_r   <= '0;
      observed_out <= '0;
    end else begin
      act_prev_r   <= ~wired_n_q;
      observed_out <= seen;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `LBS_NW; gi++) begin : g_settle
      logic [`LBS_SETTLE_W-1:0] cnt_r;
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          cnt_r <= '0;
        end else if (act_prev_r[gi] && wired_n_q[gi]) begin
          cnt_r <= `LBS_SETTLE_CLKS;
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
      assign seen[gi] = ~wired_n_q[gi] && (cnt_r == '0) && !(act_prev_r[gi] && wired_n_q[gi]);
    end
  endgenerate

  // new request only when idle, out of reset and nobody blocks
  assign req_ready_out = (state_r == LBS_IDLE) && !bus_rst && !seen[`LBS_W_BLOCK_NEXT];

  // request sequence: T1 address, T2 info, T3 partner replies, T4 observed
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LBS_IDLE: begin
        if (req_valid_in && req_ready_out) begin
          state_nxt = LBS_ADDR;
        end
      end
      LBS_ADDR:  state_nxt = LBS_INFO;
      LBS_INFO:  state_nxt = LBS_WAIT;
      LBS_WAIT:  state_nxt = LBS_CHECK;
      LBS_CHECK: state_nxt = LBS_IDLE;
      default:   state_nxt = LBS_IDLE;
    endcase
    if (bus_rst || seen[`LBS_W_BUS_INIT]) begin
      state_nxt = LBS_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= LBS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // second-clock fields are held from the accept cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      did_r <= '0;
      len_r <= '0;
    end else if (state_r == LBS_IDLE && state_nxt == LBS_ADDR) begin
      did_r <= req_did_in;
      len_r <= req_len_in;
    end
  end

  // pin drivers are flops loaded one edge ahead
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strobe_r    <= 1'b1;
      lines_out_r <= '1;
      lines_oe_r  <= 1'b0;
      parity_r    <= '0;
    end else if (state_nxt == LBS_ADDR) begin
      strobe_r    <= 1'b0;           // strobe asserted in T1
      lines_out_r <= ~req_addr_in;   // address pins 35:3
      lines_oe_r  <= 1'b1;
      parity_r    <= lbs_parity(req_addr_in);
    end else if (state_nxt == LBS_INFO) begin
      strobe_r    <= 1'b1;
      lines_out_r <= lbs_info_word(did_r, len_r); // id on pins 23:16
      lines_oe_r  <= 1'b1;
    end else begin
      strobe_r    <= 1'b1;
      lines_out_r <= '1;
      lines_oe_r  <= 1'b0;
    end
  end

  // user assertions onto the wired-or group, released during bus reset
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      drive_r <= '0;
    end else begin
      drive_r <= bus_rst ? '0 : assert_in;
    end
  end

  // reply observed in T4, result reported one clock later
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      done_out    <= 1'b0;
      fault_out   <= 1'b0;
      aborted_out <= 1'b0;
    end else begin
      done_out    <= (state_r == LBS_CHECK) && !bus_rst && !seen[`LBS_W_BUS_INIT];
      fault_out   <= (state_r == LBS_CHECK) && seen[`LBS_W_ADDR_FAULT];
      aborted_out <= (state_r != LBS_IDLE) && (bus_rst || seen[`LBS_W_BUS_INIT]);
    end
  end

  // every pin output comes straight from a flop
  assign bus.request_strobe_n = strobe_r;
  assign bus.dev_lines_out    = lines_out_r;
  assign bus.dev_lines_oe     = lines_oe_r;
  assign bus.addr_parity      = parity_r;
  assign bus.dev_wired_out    = '0;
  assign bus.dev_wired_oe     = drive_r;
endmodule : lbs_agent

/* File: lbs_defs.svh */
// constants for the latched bus signalling layer
`ifndef LBS_DEFS_SVH
`define LBS_DEFS_SVH
// request lines carry address pins 35:3, held here as index 32:0
`define LBS_ADDR_HI      35
`define LBS_ADDR_LO      3
`define LBS_AW           33
// second clock: deferred id on pins 23:16, length on pins 4:3 (line indices)
`define LBS_DID_HI       20
`define LBS_DID_LO       13
`define LBS_DID_W        8
`define LBS_LEN_HI       1
`define LBS_LEN_LO       0
`define LBS_LEN_W        2
// parity split: bit 0 covers pins 23:3, bit 1 covers pins 35:24
`define LBS_PAR_SPLIT    21
// wired-or group, one bit each
`define LBS_NW           6
`define LBS_W_BUS_INIT   0
`define LBS_W_SNOOP_HIT  1
`define LBS_W_SNOOP_MOD  2
`define LBS_W_BLOCK_NEXT 3
`define LBS_W_ADDR_FAULT 4
`define LBS_W_BUS_FAULT  5
// settling clocks after a wired-or deassertion
`define LBS_SETTLE_CLKS  2'h2
`define LBS_SETTLE_W     2
`endif

/* File: lbs_pkg.sv */
// types and helpers shared by both ends of the latched bus
`include "lbs_defs.svh"
package lbs_pkg;
  typedef logic [`LBS_AW-1:0]    lbs_lines_t;
  typedef logic [`LBS_NW-1:0]    lbs_wired_t;
  typedef logic [`LBS_DID_W-1:0] lbs_did_t;
  typedef logic [`LBS_LEN_W-1:0] lbs_len_t;
  typedef enum logic [2:0] {LBS_IDLE, LBS_ADDR, LBS_INFO, LBS_WAIT, LBS_CHECK} lbs_req_state_t;

  // even parity over the two address halves
  function automatic logic [1:0] lbs_parity(input lbs_lines_t addr);
    lbs_parity = {^addr[`LBS_AW-1:`LBS_PAR_SPLIT], ^addr[`LBS_PAR_SPLIT-1:0]};
  endfunction : lbs_parity

  // second-clock word: id and length, every other line left inactive (high)
  function automatic lbs_lines_t lbs_info_word(input lbs_did_t did, input lbs_len_t len);
    lbs_info_word = '1;
    lbs_info_word[`LBS_DID_HI:`LBS_DID_LO] = ~did;
    lbs_info_word[`LBS_LEN_HI:`LBS_LEN_LO] = ~len;
  endfunction : lbs_info_word
endpackage : lbs_pkg

/* File: lbs_bus_if.sv */
// shared bus wires, resolved from the drivers of both ends
`timescale 1ns/1ps
`include "lbs_defs.svh"
interface lbs_bus_if;
  logic                  request_strobe_n;
  logic [1:0]            addr_parity;
  logic [`LBS_AW-1:0]    dev_lines_out;
  logic                  dev_lines_oe;
  logic [`LBS_AW-1:0]    host_lines_out;
  logic                  host_lines_oe;
  logic [`LBS_AW-1:0]    lines_n;
  logic [`LBS_NW-1:0]    dev_wired_out;
  logic [`LBS_NW-1:0]    dev_wired_oe;
  logic [`LBS_NW-1:0]    host_wired_out;
  logic [`LBS_NW-1:0]    host_wired_oe;
  logic [`LBS_NW-1:0]    wired_n;
  logic                  reset_n;

  // pulled-up lines; device end wins if both drive
  assign lines_n = dev_lines_oe ? dev_lines_out : (host_lines_oe ? host_lines_out : '1);
  // wired-or: any driver pulling low makes the signal active
  assign wired_n = ~((dev_wired_oe & ~dev_wired_out) | (host_wired_oe & ~host_wired_out));

  modport dev (output request_strobe_n, addr_parity, dev_lines_out, dev_lines_oe,
               output dev_wired_out, dev_wired_oe,
               input  lines_n, wired_n, reset_n);
  modport host (output host_lines_out, host_lines_oe, host_wired_out, host_wired_oe, reset_n,
                input  request_strobe_n, addr_parity, lines_n, wired_n);
endinterface : lbs_bus_if

/* File: lbs_partner.sv */
// chipset-side agent: drives bus reset and config, receives requests
`timescale 1ns/1ps
`include "lbs_defs.svh"
module lbs_partner (
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  // bus
  lbs_bus_if.host                  bus,
  // user side
  input  wire logic                bus_reset_req_in,
  input  wire lbs_pkg::lbs_lines_t cfg_in,
  input  wire logic                busy_in,
  input  wire lbs_pkg::lbs_wired_t assert_in,
  output logic                     req_seen_out,
  output lbs_pkg::lbs_lines_t      req_addr_out,
  output lbs_pkg::lbs_did_t        req_did_out,
  output lbs_pkg::lbs_len_t        req_len_out,
  output logic                     parity_fault_out,
  output lbs_pkg::lbs_wired_t      observed_out
);
  import lbs_pkg::*;

  logic        strobe_q;
  logic [1:0]  parity_q;
  lbs_lines_t  lines_q;
  lbs_wired_t  wired_n_q;
  lbs_wired_t  act_prev_r;
  lbs_wired_t  seen;
  logic        rst_drv_r;
  logic        cfg_hold_r;
  lbs_lines_t  cfg_r;
  logic        phase_b_r;
  logic        fault_rep_r;
  logic        block_rep_r;
  lbs_wired_t  drive_r;
  logic        first;
  logic        bad;
  lbs_did_t    second_clock_request_lines_n;

  // pins straight into capture flops, no logic in front
  always_ff @(posedge clk_in) begin
    strobe_q  <= bus.request_strobe_n;
    parity_q  <= bus.addr_parity;
    lines_q   <= bus.lines_n;
    wired_n_q <= bus.wired_n;
  end

  // low on a _n pin means asserted
  assign first = ~strobe_q;
  assign bad   = lbs_parity(~lines_q) != parity_q;
  assign second_clock_request_lines_n = lines_q[`LBS_DID_HI:`LBS_DID_LO];

  // bus reset with config held on the lines one clock past release
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rst_drv_r  <= 1'b1;
      cfg_hold_r <= 1'b0;
      cfg_r      <= '1;
    end else begin
      rst_drv_r  <= bus_reset_req_in;
      cfg_hold_r <= rst_drv_r;
      if (rst_drv_r) begin
        cfg_r <= ~cfg_in;
      end
    end
  end

  // request seen in T2, id captured on the second clock
  always_ff @(posedge clk_in) begin
    if (reset_in || rst_drv_r) begin
      phase_b_r    <= 1'b0;
      req_seen_out <= 1'b0;
      req_addr_out <= '0;
      req_did_out  <= '0;
      req_len_out  <= '0;
    end else begin
      phase_b_r    <= first;
      req_seen_out <= phase_b_r;
      if (first) begin
        req_addr_out <= ~lines_q;
      end
      if (phase_b_r) begin
        req_did_out <= ~second_clock_request_lines_n;
        req_len_out <= ~lines_q[`LBS_LEN_HI:`LBS_LEN_LO];
      end
    end
  end

  // decide in T2, reply asserted in T3 from a flop
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fault_rep_r      <= 1'b0;
      parity_fault_out <= 1'b0;
      block_rep_r      <= 1'b0;
      drive_r          <= '0;
    end else begin
      fault_rep_r      <= first && bad;
      parity_fault_out <= first && bad;
      block_rep_r      <= busy_in;
      drive_r          <= assert_in;
    end
  end

  // ignore a wired-or signal for two clocks after it goes inactive
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      act_prev_r   <= '0;
      observed_out <= '0;
    end else begin
      act_prev_r   <= ~wired_n_q;
      observed_out <= seen;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `LBS_NW; gi++) begin : g_settle
      logic [`LBS_SETTLE_W-1:0] cnt_r;
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          cnt_r <= '0;
        end else if (act_prev_r[gi] && wired_n_q[gi]) begin
          cnt_r <= `LBS_SETTLE_CLKS;
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
      assign seen[gi] = ~wired_n_q[gi] && (cnt_r == '0) && !(act_prev_r[gi] && wired_n_q[gi]);
    end
  endgenerate

  // outputs from flops, through at most an inverter or an OR of two flops
  assign bus.reset_n        = ~rst_drv_r;
  assign bus.host_lines_out = cfg_r;
  assign bus.host_lines_oe  = rst_drv_r | cfg_hold_r;
  assign bus.host_wired_out = '0;
  always_comb begin
    bus.host_wired_oe = drive_r;
    bus.host_wired_oe[`LBS_W_ADDR_FAULT] = drive_r[`LBS_W_ADDR_FAULT] | fault_rep_r;
    bus.host_wired_oe[`LBS_W_BLOCK_NEXT] = drive_r[`LBS_W_BLOCK_NEXT] | block_rep_r;
  end
endmodule : lbs_partner

/* File: lbs_properties.sv */
// concurrent checks on the shared request bus between the two ends
`timescale 1ns/1ps
`include "lbs_defs.svh"
module lbs_properties (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  // bus
  input  wire logic               request_strobe_n,
  input  wire logic [1:0]         addr_parity,
  input  wire logic [`LBS_AW-1:0] dev_lines_out,
  input  wire logic               dev_lines_oe,
  input  wire logic               host_lines_oe,
  input  wire logic [`LBS_NW-1:0] dev_wired_out,
  input  wire logic [`LBS_NW-1:0] dev_wired_oe,
  input  wire logic [`LBS_NW-1:0] host_wired_out,
  input  wire logic [`LBS_NW-1:0] host_wired_oe,
  input  wire logic               reset_n
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence req_first;
    $fell(request_strobe_n) && dev_lines_oe;
  endsequence
  sequence req_second;
    (request_strobe_n && dev_lines_oe) ##1 !dev_lines_oe;
  endsequence
  sequence bus_reset_seen;
    !reset_n [*4];
  endsequence

  a_request_two_clocks: assert property (req_first |=> req_second)
    else $error("request phase is not two clocks");
  a_strobe_spacing: assert property ($fell(request_strobe_n) |=> request_strobe_n [*4])
    else $error("strobe again before the previous request ended");
  a_addr_lines_driven: assert property (!request_strobe_n |-> dev_lines_oe)
    else $error("address clock without lines driven");
  a_parity_even: assert property (!request_strobe_n |-> addr_parity ==
    {^(~dev_lines_out[32:21]), ^(~dev_lines_out[20:0])})
    else $error("address parity wrong");
  a_info_idle_high: assert property ($fell(request_strobe_n) |=>
    (&dev_lines_out[32:21]) && (&dev_lines_out[12:2]))
    else $error("unused second clock lines not inactive");
  a_lines_only_request: assert property (dev_lines_oe |->
    !request_strobe_n || !$past(request_strobe_n))
    else $error("request lines driven outside the request phase");
  a_quiet_in_reset: assert property (bus_reset_seen |->
    request_strobe_n && !dev_lines_oe && dev_wired_oe == '0)
    else $error("agent drives the bus during bus reset");
  a_cfg_held_past: assert property ($rose(reset_n) |-> host_lines_oe)
    else $error("config lines released at reset release edge");
  a_host_lines_reset: assert property (host_lines_oe |-> !reset_n || !$past(reset_n))
    else $error("partner drives lines outside bus reset");
  a_wired_low_active: assert property (|(dev_wired_oe | host_wired_oe) |->
    ((dev_wired_oe & dev_wired_out) | (host_wired_oe & host_wired_out)) == '0)
    else $error("wired signal driven high");
endmodule : lbs_properties

/* File: latched_bus_signaling_bench.sv */
// self-checking bench for both bus ends joined by the shared bus
`timescale 1ns/1ps
module latched_bus_signaling_bench;
  import lbs_pkg::*;
  logic       clk_in;
  logic       reset_in;
  logic       req_valid_in;
  logic       bus_reset_req_in;
  logic       busy_in;
  logic       req_ready_out;
  logic       done_out;
  logic       fault_out;
  logic       cfg_valid_out;
  logic       in_reset_out;
  logic       req_seen_out;
  logic       aborted_out;
  lbs_lines_t req_addr_in;
  lbs_lines_t cfg_in;
  lbs_lines_t cfg_out;
  lbs_lines_t p_addr;
  lbs_did_t   req_did_in;
  lbs_did_t   p_did;
  lbs_len_t   req_len_in;
  lbs_len_t   p_len;
  lbs_wired_t a_assert;
  lbs_wired_t a_obs;
  lbs_wired_t p_obs;
  lbs_wired_t p_assert;
  int         n_errors;
  int         num_checks;
  int         cycles;
  lbs_lines_t addr_tab [4] = '{33'h0, 33'h1_ffff_ffff, 33'h1_0000_0001, 33'h0_aaaa_5555};
  lbs_did_t   did_tab [4]  = '{8'h00, 8'hff, 8'h5a, 8'h81};

  lbs_bus_if bus_if ();
  lbs_agent lbs_agent_inst (.clk_in(clk_in), .reset_in(reset_in), .bus(bus_if.dev),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_addr_in(req_addr_in),
    .req_did_in(req_did_in), .req_len_in(req_len_in), .done_out(done_out),
    .fault_out(fault_out), .aborted_out(aborted_out),
    .assert_in(a_assert), .observed_out(a_obs),
    .cfg_out(cfg_out), .cfg_valid_out(cfg_valid_out), .in_reset_out(in_reset_out));
  lbs_partner lbs_partner_inst (.clk_in(clk_in), .reset_in(reset_in), .bus(bus_if.host),
    .bus_reset_req_in(bus_reset_req_in), .cfg_in(cfg_in), .busy_in(busy_in),
    .assert_in(p_assert), .req_seen_out(req_seen_out), .req_addr_out(p_addr),
    .req_did_out(p_did), .req_len_out(p_len), .parity_fault_out(), .observed_out(p_obs));
  lbs_properties lbs_properties_inst (.clk_in(clk_in), .reset_in(reset_in),
    .request_strobe_n(bus_if.request_strobe_n), .addr_parity(bus_if.addr_parity),
    .dev_lines_out(bus_if.dev_lines_out), .dev_lines_oe(bus_if.dev_lines_oe),
    .host_lines_oe(bus_if.host_lines_oe), .dev_wired_out(bus_if.dev_wired_out),
    .dev_wired_oe(bus_if.dev_wired_oe), .host_wired_out(bus_if.host_wired_out),
    .host_wired_oe(bus_if.host_wired_oe), .reset_n(bus_if.reset_n));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // counts edges until the flag is seen, sampled just after each edge
  task automatic wait_cfg(output int n);
    n = 0;
    do begin @(posedge clk_in); #1; n++; end while (cfg_valid_out !== 1'b1 && n < 40);
  endtask : wait_cfg

  task automatic do_req(input lbs_lines_t a, input lbs_did_t d, input lbs_len_t l,
                        input logic f);
    int n;
    int seen;
    @(posedge clk_in);
    req_addr_in  <= a;
    req_did_in   <= d;
    req_len_in   <= l;
    req_valid_in <= 1'b1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (req_ready_out !== 1'b1 && n < 50);
    req_valid_in <= 1'b0;
    #1;
    chk("strobe", 33'h0, bus_if.request_strobe_n);
    chk("t1 lines", ~a, bus_if.lines_n);
    @(posedge clk_in);
    #1;
    chk("t2 id", {25'h0, ~d}, {25'h0, bus_if.lines_n[20:13]});
    chk("t2 len", {31'h0, ~l}, {31'h0, bus_if.lines_n[1:0]});
    n = 2;
    seen = 0;
    while (done_out !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      #1;
      n++;
      if (req_seen_out === 1'b1) seen = n;
    end
    chk("done cycle", 33'd5, 33'(n));
    chk("seen cycle", 33'd4, 33'(seen));
    chk("fault", {32'h0, f}, {32'h0, fault_out});
    chk("partner addr", a, p_addr);
    chk("partner id", {25'h0, d}, {25'h0, p_did});
    chk("partner len", {31'h0, l}, {31'h0, p_len});
  endtask : do_req

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    int n;
    reset_in = 1'b1;
    bus_reset_req_in = 1'b1;
    busy_in = 1'b0;
    req_valid_in = 1'b0;
    req_addr_in = '0;
    req_did_in = '0;
    req_len_in = '0;
    a_assert = '0;
    p_assert = '0;
    cfg_in = 33'h1_2345_6789;
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    bus_reset_req_in <= 1'b0;
    wait_cfg(n);
    chk("cfg delay", 33'd3, 33'(n));
    chk("cfg value", 33'h1_2345_6789, cfg_out);
    chk("in reset", 33'h0, in_reset_out);
    @(posedge clk_in);
    cfg_in <= 33'h0_fedc_ba98;
    repeat (4) @(posedge clk_in);
    bus_reset_req_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    chk("cfg held", 33'h1_2345_6789, cfg_out);
    chk("valid in reset", 33'h0, cfg_valid_out);
    chk("ready in reset", 33'h0, req_ready_out);
    @(posedge clk_in);
    bus_reset_req_in <= 1'b0;
    wait_cfg(n);
    chk("cfg new", 33'h0_fedc_ba98, cfg_out);
    $display("test config done");
    for (int i = 0; i < 4; i++) do_req(addr_tab[i], did_tab[i], i[1:0], 1'b0);
    $display("test requests done");
    for (int b = 0; b < 6; b++) begin
      @(posedge clk_in);
      a_assert <= lbs_wired_t'(1 << b);
      n = 0;
      do begin @(posedge clk_in); #1; n++; end while (p_obs[b] !== 1'b1 && n < 20);
      chk("wired delay", 33'd3, 33'(n));
      chk("agent wired", 33'h1, {32'h0, a_obs[b]});
      chk("wired level", 33'h0, bus_if.wired_n[b]);
      @(posedge clk_in);
      a_assert <= '0;
      @(posedge clk_in);
      // one-clock gap: seen inactive once, then hidden for the two settle clocks
      a_assert <= lbs_wired_t'(1 << b);
      n = 0;
      repeat (8) begin @(posedge clk_in); #1; if (p_obs[b] === 1'b0) n++; end
      chk("settle lows", 33'd3, 33'(n));
      @(posedge clk_in);
      a_assert <= '0;
      repeat (6) @(posedge clk_in);
    end
    $display("test wired done");
    @(posedge clk_in);
    busy_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    chk("busy wire", 33'h0, bus_if.wired_n[3]);
    chk("busy ready", 33'h0, req_ready_out);
    @(posedge clk_in);
    busy_in <= 1'b0;
    do_req(33'h1_5555_aaaa, 8'h3c, 2'h3, 1'b0);
    $display("test busy done");
    // partner holds the address fault line, so the agent reports a fault with done
    @(posedge clk_in);
    p_assert <= 6'h10;
    do_req(33'h0_0f0f_0f0f, 8'h96, 2'h1, 1'b1);
    @(posedge clk_in);
    p_assert <= '0;
    repeat (6) @(posedge clk_in);
    $display("test fault done");
    // bus init from the partner kills a request in flight
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (req_ready_out !== 1'b1 && n < 50);
    req_valid_in <= 1'b0;
    p_assert     <= 6'h01;
    repeat (3) @(posedge clk_in);
    #1;
    chk("aborted", 33'h1, {32'h0, aborted_out});
    chk("no done", 33'h0, {32'h0, done_out});
    @(posedge clk_in);
    #1;
    chk("aborted pulse", 33'h0, {32'h0, aborted_out});
    p_assert <= '0;
    repeat (8) @(posedge clk_in);
    $display("test abort done");
    tally_and_finish();
  end
endmodule : latched_bus_signaling_bench
